// ### inc/frbg_pkg.sv
// Shared constants and types for the fractional rate generator
`default_nettype none
package frbg_pkg;

  // Core clock rate
  localparam int unsigned CORE_CLK_HZ = 250_000_000;

  // Channel indices
  localparam int CHANNELS = 2;
  localparam int CH_A = 0;
  localparam int CH_B = 1;

  // Register select codes on the host address pins
  localparam logic [1:0] ADDR_DIV_LOW = 2'h0;
  localparam logic [1:0] ADDR_DIV_HIGH = 2'h1;
  localparam logic [1:0] ADDR_DIV_FRAC = 2'h2;
  localparam logic [1:0] ADDR_MODEM_CTRL = 2'h3;

  // Reset values
  localparam logic [7:0] DIV_LOW_RESET = 8'h01;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] DIV_FRAC_RESET = 8'h00;
  localparam logic PRESCALE_RESET = 1'b0;

  // Field layout
  localparam int PRESCALE_BIT = 7;
  localparam int FRAC_MSB = 3;
  localparam int MODE_MSB = 5;
  localparam int MODE_LSB = 4;
  localparam logic [7:0] FRAC_REG_MASK = 8'h3f;

  // Synchronised pin vector: cs_a_b, cs_b_b, ior_b, iow_b, addr, data
  localparam int PIN_W = 14;
  localparam logic [13:0] PIN_IDLE = 14'h3c00;

  // Divide-by-four prescaler end count
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // Oversampling modes
  typedef enum logic [1:0] {
    MODE_16X = 2'h0,
    MODE_8X = 2'h1,
    MODE_4X = 2'h2
  } sample_mode_t;

  localparam logic [3:0] RATIO_LAST_16X = 4'hf;
  localparam logic [3:0] RATIO_LAST_8X = 4'h7;
  localparam logic [3:0] RATIO_LAST_4X = 4'h3;

  // Last sample index of a bit period; the reserved code acts as 16X
  function automatic logic [3:0] ratio_last(input logic [1:0] mode);
    case (mode)
      MODE_8X: ratio_last = RATIO_LAST_8X;
      MODE_4X: ratio_last = RATIO_LAST_4X;
      default: ratio_last = RATIO_LAST_16X;
    endcase
  endfunction

endpackage
`default_nettype wire

// ### inc/brg_if.sv
// Configuration and tick signals between register file and one generator
`default_nettype none
interface brg_if;
  logic [15:0] int_part;
  logic [3:0] frac;
  logic [1:0] mode;
  logic prescale;
  logic sample_tick;
  logic bit_tick;

  modport cfg (
    output int_part,
    output frac,
    output mode,
    output prescale,
    input sample_tick,
    input bit_tick
  );

  modport gen (
    input int_part,
    input frac,
    input mode,
    input prescale,
    output sample_tick,
    output bit_tick
  );
endinterface
`default_nettype wire

// ### rtl/rate_generator.sv
// One channel's prescaler and fractional divider
`default_nettype none
module rate_generator
  import frbg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  brg_if.gen g
);

  logic [1:0] pre_cnt;
  logic pre_tick;
  logic [16:0] div_cnt;
  logic [3:0] acc;
  logic [3:0] next_acc;
  logic carry;
  logic [15:0] int_eff;
  logic [16:0] next_period;
  logic tick_now;
  logic [3:0] samp_cnt;
  logic bit_now;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler: divide by 1 or 4
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pre_cnt <= 2'h0;
    else if (clk_en)
      pre_cnt <= g.prescale ? pre_cnt + 2'h1 : 2'h0;
  end

  assign pre_tick = clk_en && (!g.prescale || pre_cnt == PRESCALE_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Period of the next sample clock: integer part plus a spread fraction
  assign int_eff = (g.int_part == 16'h0) ? 16'h1 : g.int_part;
  assign {carry, next_acc} = {1'b0, acc} + {1'b0, g.frac};
  assign next_period = {1'b0, int_eff} + {16'h0, carry};
  assign tick_now = pre_tick && div_cnt == 17'h0;

  // Divider down counter and phase accumulator; odd fractions in 8X/4X
  // leave one bit period a sixteenth long or short
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_cnt <= 17'h0;
      acc <= 4'h0;
    end
    else if (tick_now)
    begin
      div_cnt <= next_period - 17'h1;
      acc <= next_acc;
    end
    else if (pre_tick)
      div_cnt <= div_cnt - 17'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Samples per bit period
  assign bit_now = tick_now && samp_cnt >= ratio_last(g.mode);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      samp_cnt <= 4'h0;
    else if (tick_now)
      samp_cnt <= bit_now ? 4'h0 : samp_cnt + 4'h1;
  end

  // Registered tick outputs to the shifters
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      g.sample_tick <= 1'b0;
      g.bit_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      g.sample_tick <= tick_now;
      g.bit_tick <= bit_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checking helpers
  logic [16:0] pre_since;
  logic [16:0] last_period;
  logic [3:0] tick_num;
  logic [4:0] extra_sum;
  logic [3:0] frac_prev;
  logic win_ok;
  logic [1:0] mode_prev;
  logic mode_moved;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_since <= 17'h0;
      last_period <= 17'h1;
      tick_num <= 4'h0;
      extra_sum <= 5'h0;
      frac_prev <= 4'h0;
      win_ok <= 1'b1;
      mode_prev <= 2'h0;
      mode_moved <= 1'b0;
    end
    else
    begin
      frac_prev <= g.frac;
      mode_prev <= g.mode;
      // A mode change leaves one bit period of odd length until the next bit
      if (bit_now)
        mode_moved <= 1'b0;
      else if (g.mode != mode_prev)
        mode_moved <= 1'b1;
      if (tick_now)
      begin
        pre_since <= 17'h0;
        last_period <= next_period;
        tick_num <= tick_num + 4'h1;
        extra_sum <= (tick_num == 4'hf) ? 5'h0 : extra_sum + {4'h0, carry};
      end
      else if (pre_tick)
        pre_since <= pre_since + 17'h1;
      if (tick_now && tick_num == 4'hf)
        win_ok <= 1'b1;
      else if (g.frac != frac_prev)
        win_ok <= 1'b0;
    end
  end

  prescale_gap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    pre_tick && g.prescale |=> (!pre_tick || !g.prescale)[*3])
    else $error("prescaled tick came early");

  tick_gap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    tick_now |-> pre_since + 17'h1 == last_period)
    else $error("sample period differs from divisor");

  bit_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    bit_now && !mode_moved && !$changed(g.mode) |-> samp_cnt == ratio_last(g.mode))
    else $error("bit period has wrong sample count");

  frac_spread_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    tick_now && tick_num == 4'hf && win_ok && g.frac == frac_prev
      |-> extra_sum + {4'h0, carry} == {1'b0, g.frac})
    else $error("stretched periods do not match fraction");

  tick_out_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    tick_now |=> g.sample_tick)
    else $error("sample tick not presented");

  cover_4x_bit_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    bit_now && g.mode == MODE_4X);
  cover_prescaled_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    tick_now && g.prescale);
  cover_stretch_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    tick_now && carry);

endmodule
`default_nettype wire

// ### rtl/fractional_baud_rate_generator.sv
// Two-channel fractional rate generator with its divisor registers
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Each channel owns its generator and prescaler
// - Control bit 7 picks divide by 1 or 4
// - Divisor 1 to just under 65536, sixteenths
// - Output ticks pace shifting and sampling
// - Reset: low byte 01, others 00
// - Low and high bytes form integer part
// - Only four fraction bits are implemented
// - Bits 5:4 choose 16X, 8X or 4X
// - Rate equals clock over prescale, divisor, ratio
// - Odd fractions in 8X/4X jitter a sixteenth
// - A single clock, core_clk, clocks the generators, the host pins and the registers
// - Bit lasts 16, 8 or 4 samples
module fractional_baud_rate_generator
  import frbg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cs_a_b,
  input wire logic cs_b_b,
  input wire logic ior_b,
  input wire logic iow_b,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic sample_tick_a,
  output logic bit_tick_a,
  output logic sample_tick_b,
  output logic bit_tick_b
);

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic iow_prev;
  logic [CHANNELS-1:0] cs_act;
  logic s_ior_b;
  logic s_iow_b;
  logic [1:0] s_addr;
  logic [7:0] s_data;
  logic wr_strobe;
  logic [CHANNELS-1:0] wr_ch;
  logic rd_active;
  logic rd_ch;

  logic [7:0] div_low [CHANNELS];
  logic [7:0] div_high [CHANNELS];
  logic [7:0] div_frac [CHANNELS];
  logic prescale [CHANNELS];

  ////////////////////////////////////////////////////////////////////////
  // Host pins pass two flops before any use
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end
    else if (clk_en)
    begin
      pin_meta <= {cs_a_b, cs_b_b, ior_b, iow_b, reg_addr, data_in};
      pin_sync <= pin_meta;
    end
  end

  // Named fields of the synchronised pins
  assign cs_act[CH_A] = !pin_sync[13];
  assign cs_act[CH_B] = !pin_sync[12];
  assign s_ior_b = pin_sync[11];
  assign s_iow_b = pin_sync[10];
  assign s_addr = pin_sync[9:8];
  assign s_data = pin_sync[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Write detect: the rising edge of the write strobe commits the byte
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      iow_prev <= 1'b1;
    else if (clk_en)
      iow_prev <= s_iow_b;
  end

  assign wr_strobe = clk_en && s_iow_b && !iow_prev;
  // Both selects together write both channels at once
  assign wr_ch = wr_strobe ? cs_act : 2'b00;

  ////////////////////////////////////////////////////////////////////////
  // Per-channel divisor registers and prescale control
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        div_low[i] <= DIV_LOW_RESET;
        div_high[i] <= DIV_HIGH_RESET;
        div_frac[i] <= DIV_FRAC_RESET;
        prescale[i] <= PRESCALE_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (wr_ch[i])
        begin
          case (s_addr)
            ADDR_DIV_LOW: div_low[i] <= s_data;
            ADDR_DIV_HIGH: div_high[i] <= s_data;
            ADDR_DIV_FRAC: div_frac[i] <= s_data & FRAC_REG_MASK;
            ADDR_MODEM_CTRL: prescale[i] <= s_data[PRESCALE_BIT];
            default: div_low[i] <= div_low[i];
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read mux for one channel
  function automatic logic [7:0] reg_read(input logic ch, input logic [1:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ADDR_DIV_LOW: v = div_low[ch];
      ADDR_DIV_HIGH: v = div_high[ch];
      ADDR_DIV_FRAC: v = div_frac[ch];
      ADDR_MODEM_CTRL: v[PRESCALE_BIT] = prescale[ch];
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Channel A wins if both selects are low during a read
  assign rd_active = !s_ior_b && (cs_act != 2'b00);
  assign rd_ch = cs_act[CH_A] ? 1'b0 : 1'b1;
  assign data_oe = rd_active;

  // Read data register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      data_out <= 8'h00;
    else if (clk_en && rd_active)
      data_out <= reg_read(rd_ch, s_addr);
  end

  ////////////////////////////////////////////////////////////////////////
  // One generator per channel
  brg_if ch_if [CHANNELS] ();

  for (genvar c = 0; c < CHANNELS; c++)
  begin : gen_ch
    assign ch_if[c].int_part = {div_high[c], div_low[c]};
    assign ch_if[c].frac = div_frac[c][FRAC_MSB:0];
    assign ch_if[c].mode = div_frac[c][MODE_MSB:MODE_LSB];
    assign ch_if[c].prescale = prescale[c];

    rate_generator u_gen (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .g(ch_if[c])
    );
  end

  // Tick outputs to each channel's shifters
  assign sample_tick_a = ch_if[CH_A].sample_tick;
  assign bit_tick_a = ch_if[CH_A].bit_tick;
  assign sample_tick_b = ch_if[CH_B].sample_tick;
  assign bit_tick_b = ch_if[CH_B].bit_tick;

  ////////////////////////////////////////////////////////////////////////
  // Checking helpers
  logic wr_seen;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      wr_seen <= 1'b0;
    else if (wr_strobe && cs_act != 2'b00)
      wr_seen <= 1'b1;
  end

  reset_value_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !wr_seen |-> div_low[CH_A] == DIV_LOW_RESET && div_high[CH_A] == DIV_HIGH_RESET
      && div_frac[CH_A] == DIV_FRAC_RESET && div_low[CH_B] == DIV_LOW_RESET
      && div_high[CH_B] == DIV_HIGH_RESET && div_frac[CH_B] == DIV_FRAC_RESET)
    else $error("divisor left its reset value without a write");

  channel_isolation_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_ch == 2'b01 |=> $stable(div_low[CH_B]) && $stable(div_high[CH_B])
      && $stable(div_frac[CH_B]) && $stable(prescale[CH_B]))
    else $error("write to channel A changed channel B");

  low_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_ch[CH_A] && s_addr == ADDR_DIV_LOW
      |=> ch_if[CH_A].int_part[7:0] == $past(s_data))
    else $error("low divisor byte not taken");

  high_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_ch[CH_B] && s_addr == ADDR_DIV_HIGH
      |=> ch_if[CH_B].int_part[15:8] == $past(s_data))
    else $error("high divisor byte not taken");

  frac_bits_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    div_frac[CH_A][7:6] == 2'h0 && div_frac[CH_B][7:6] == 2'h0)
    else $error("unimplemented fraction bits set");

  prescale_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_ch[CH_A] && s_addr == ADDR_MODEM_CTRL
      ##1 !wr_ch[CH_A] [*2] |-> ch_if[CH_A].prescale == $past(s_data[PRESCALE_BIT], 2))
    else $error("prescale select not taken");

  read_back_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && rd_active && rd_ch == 1'b0 && s_addr == ADDR_DIV_FRAC
      |=> data_out == {2'h0, $past(div_frac[CH_A][5:0])})
    else $error("fraction register read back wrong");

  cover_both_write_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    wr_ch == 2'b11);
  cover_read_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    rd_active && rd_ch);

endmodule
`default_nettype wire

// ### bench/tb_fractional_baud_rate_generator.sv
// Self-checking bench for the two-channel fractional rate generator
`default_nettype none

module tb_fractional_baud_rate_generator
  import frbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic cs_a_b = 1'b1;
  logic cs_b_b = 1'b1;
  logic ior_b = 1'b1;
  logic iow_b = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out;
  logic data_oe;
  logic sample_tick_a;
  logic bit_tick_a;
  logic sample_tick_b;
  logic bit_tick_b;
  int errors = 0;
  int checks = 0;

  // Divisor settings and expected cycles over sixteen sample periods
  logic [7:0] lo_tab [7] = '{8'h02, 8'h03, 8'h03, 8'h03, 8'h01, 8'h01, 8'h00};
  logic [7:0] hi_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] fr_tab [7] = '{8'hc8, 8'h15, 8'h2f, 8'h30, 8'h20, 8'h00, 8'h01};
  logic [7:0] mc_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h7f, 8'hff, 8'h00, 8'hff};
  int cyc_tab [7] = '{40, 53, 63, 48, 64, 4112, 68};
  int bit_tab [7] = '{1, 2, 4, 1, 4, 1, 1};

  fractional_baud_rate_generator DUT (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .cs_a_b(cs_a_b),
    .cs_b_b(cs_b_b),
    .ior_b(ior_b),
    .iow_b(iow_b),
    .reg_addr(reg_addr),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .sample_tick_a(sample_tick_a),
    .bit_tick_a(bit_tick_a),
    .sample_tick_b(sample_tick_b),
    .bit_tick_b(bit_tick_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Final counts and verdict
  task conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compare one seen value with its expected value
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Host write: strobe held low 3 cycles, selects held past the sync delay
  task wr(input logic sa, input logic sb, input logic [1:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cs_a_b = sa;
    cs_b_b = sb;
    reg_addr = a;
    data_in = d;
    iow_b = 1'b0;
    repeat (3) @(negedge core_clk);
    iow_b = 1'b1;
    repeat (4) @(negedge core_clk);
    cs_a_b = 1'b1;
    cs_b_b = 1'b1;
  endtask

  // Host read: wait for the output enable, take data one cycle later
  task rd_check(input logic sa, input logic sb, input logic [1:0] a, input logic [7:0] exp);
    int n;
    @(negedge core_clk);
    cs_a_b = sa;
    cs_b_b = sb;
    reg_addr = a;
    ior_b = 1'b0;
    n = 0;
    while (data_oe !== 1'b1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 10)
    begin
      errors++;
      $display("BAD at %0t: read never enabled", $time);
      conclude();
    end
    @(negedge core_clk);
    check({24'h0, data_out}, {24'h0, exp});
    ior_b = 1'b1;
    repeat (4) @(negedge core_clk);
    cs_a_b = 1'b1;
    cs_b_b = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  // Skip three ticks for reload, then time sixteen sample periods
  task measure(input logic ch, input int cyc, input int bits);
    int n;
    int t;
    int c;
    int b;
    n = 0;
    t = 0;
    c = 0;
    b = 0;
    while (t < 19 && n < 8000)
    begin
      @(negedge core_clk);
      n++;
      if (t >= 3)
        c++;
      if ((ch ? sample_tick_b : sample_tick_a) === 1'b1)
      begin
        t++;
        if (t > 3 && (ch ? bit_tick_b : bit_tick_a) === 1'b1)
          b++;
      end
    end
    if (n >= 8000)
    begin
      errors++;
      $display("BAD at %0t: sample ticks stopped", $time);
      conclude();
    end
    check(c, cyc);
    check(b, bits);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
    // Reset values on both channels
    rd_check(1'b0, 1'b1, ADDR_DIV_LOW, 8'h01);
    rd_check(1'b0, 1'b1, ADDR_DIV_HIGH, 8'h00);
    rd_check(1'b0, 1'b1, ADDR_DIV_FRAC, 8'h00);
    rd_check(1'b1, 1'b0, ADDR_DIV_LOW, 8'h01);
    rd_check(1'b1, 1'b0, ADDR_MODEM_CTRL, 8'h00);
    measure(1'b0, 16, 1);
    measure(1'b1, 16, 1);
    $display("test reset_defaults done");
    // Divisor table on channel A, readback masked to implemented bits
    for (int i = 0; i < 7; i++)
    begin
      wr(1'b0, 1'b1, ADDR_DIV_LOW, lo_tab[i]);
      wr(1'b0, 1'b1, ADDR_DIV_HIGH, hi_tab[i]);
      wr(1'b0, 1'b1, ADDR_DIV_FRAC, fr_tab[i]);
      wr(1'b0, 1'b1, ADDR_MODEM_CTRL, mc_tab[i]);
      rd_check(1'b0, 1'b1, ADDR_DIV_HIGH, hi_tab[i]);
      rd_check(1'b0, 1'b1, ADDR_DIV_FRAC, fr_tab[i] & FRAC_REG_MASK);
      rd_check(1'b0, 1'b1, ADDR_MODEM_CTRL, mc_tab[i] & 8'h80);
      measure(1'b0, cyc_tab[i], bit_tab[i]);
    end
    $display("test divisor_table done");
    // Channel B kept its defaults while A was reprogrammed
    rd_check(1'b1, 1'b0, ADDR_DIV_FRAC, 8'h00);
    measure(1'b1, 16, 1);
    $display("test channel_isolation done");
    // Both selects low writes both channels
    wr(1'b0, 1'b0, ADDR_DIV_LOW, 8'h05);
    wr(1'b0, 1'b0, ADDR_DIV_HIGH, 8'h00);
    wr(1'b0, 1'b0, ADDR_DIV_FRAC, 8'h13);
    wr(1'b0, 1'b0, ADDR_MODEM_CTRL, 8'h00);
    rd_check(1'b1, 1'b0, ADDR_DIV_LOW, 8'h05);
    rd_check(1'b0, 1'b1, ADDR_DIV_LOW, 8'h05);
    measure(1'b1, 83, 2);
    measure(1'b0, 83, 2);
    $display("test dual_write done");
    // Frozen clock enable: a pin write is never taken
    clk_en = 1'b0;
    wr(1'b0, 1'b1, ADDR_DIV_LOW, 8'h09);
    clk_en = 1'b1;
    rd_check(1'b0, 1'b1, ADDR_DIV_LOW, 8'h05);
    $display("test clock_freeze done");
    conclude();
  end

endmodule

`default_nettype wire
